/* logic/flash_status_tracker.sv */
// Operation
// - Read-status command makes even reads return status in mode zero
// - Program or erase start selects status reads
// - Sequence flag D7: busy 0, ready 1
// - Erase suspend keeps sequence flag busy
// - Erase error flag at D5, resets 0
// - Program error flag at D4, resets 0
// - Status byte driven on data D7..D0
// - Clear-status clears both error flags
// - Error flag set blocks program and erase
// - Invalid command sets both error flags
// - Bad erase confirm byte is sequence error
// - Protected block program/erase sets both flags
// - Failed erase sets erase flag only
// - Failed program sets program flag only
// - Read-array in erase second cycle cancels command; program takes it as data
// - Read-status code 70, status on next read
// - Clear-status code 50, single cycle
// - Program code 40 then data, same address
// - Erase code 20 then D0 confirm
`timescale 1ns/1ps
`default_nettype none

module flash_status_tracker #(
    parameter int unsigned ADDR_W = 20
) (
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    // CPU write strobe, same clock domain
    input  wire logic              cmd_wr_in,
    input  wire logic [ADDR_W-1:0] cmd_addr_in,
    input  wire logic [15:0]       cmd_data_in,
    // CPU read strobe of an even user-ROM address
    input  wire logic              rom_rd_in,
    input  wire logic [15:0]       array_data_in,
    // Block protection of the addressed block
    input  wire logic              block_protect_in,
    // Flash core sequencing
    input  wire logic              core_done_in,
    input  wire logic              core_fail_in,
    input  wire logic              erase_suspend_in,
    input  wire logic              erase_write_mode_zero_in,
    // Core launch requests
    output logic                   prog_start_out,
    output logic                   erase_start_out,
    output logic [ADDR_W-1:0]      op_addr_out,
    output logic [15:0]            op_data_out,
    // Read answer
    output logic [15:0]            rd_data_out,
    output logic                   rd_valid_out,
    // Status views
    output logic [7:0]             flash_status_byte_out,
    output logic [7:0]             flash_control_reg0_out
);

    logic                     rst_meta_q;
    logic                     rst_sync_q;
    logic                     seq_ready_flag_q;
    logic                     erase_error_flag_q;
    logic                     program_error_flag_q;
    logic                     op_is_erase_q;
    flash_status_pkg::read_mode_e rd_mode_q;
    flash_status_pkg::seq_state_e state_q;
    logic [7:0]               status_byte_d;
    logic [7:0]               cmd_lo;
    logic                     err_any;
    logic                     busy;
    logic                     wr_idle;
    logic                     start_prog;
    logic                     start_erase;
    logic                     seq_error;
    logic                     op_fail;

    // Reset release through two flops; async assert only
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Command decode; high byte is ignored
    assign cmd_lo   = cmd_data_in[7:0];
    assign err_any  = erase_error_flag_q | program_error_flag_q;
    assign busy     = ~seq_ready_flag_q;
    // Writes while the core runs are ignored, the array is unreachable then
    assign wr_idle  = cmd_wr_in & ~busy;

    // Second cycle launches; refused while an error flag is up
    assign start_prog  = wr_idle && (state_q == flash_status_pkg::SEQ_PROG_WD)
                         && !err_any && !block_protect_in;
    assign start_erase = wr_idle && (state_q == flash_status_pkg::SEQ_ERASE_C)
                         && (cmd_lo == flash_status_pkg::CMD_ERASE_CONF)
                         && !err_any && !block_protect_in;

    // Sequence errors: unknown code, bad confirm, protected target
    always_comb
    begin
        seq_error = 1'b0;
        if (wr_idle)
        begin
            unique case (state_q)
                flash_status_pkg::SEQ_IDLE:
                begin
                    seq_error = !(cmd_lo == flash_status_pkg::CMD_READ_ARRAY
                               || cmd_lo == flash_status_pkg::CMD_READ_STATUS
                               || cmd_lo == flash_status_pkg::CMD_CLEAR_STATUS
                               || cmd_lo == flash_status_pkg::CMD_PROGRAM
                               || cmd_lo == flash_status_pkg::CMD_BLOCK_ERASE);
                end
                flash_status_pkg::SEQ_PROG_WD:
                begin
                    seq_error = !err_any && block_protect_in;
                end
                flash_status_pkg::SEQ_ERASE_C:
                begin
                    if (cmd_lo == flash_status_pkg::CMD_READ_ARRAY)
                        seq_error = 1'b0;
                    else if (cmd_lo != flash_status_pkg::CMD_ERASE_CONF)
                        seq_error = 1'b1;
                    else
                        seq_error = !err_any && block_protect_in;
                end
                default:
                begin
                    seq_error = 1'b0;
                end
            endcase
        end
    end

    // Core failure once it reports done
    assign op_fail = busy && core_done_in && core_fail_in && !erase_suspend_in;

    // Command sequencer: first cycle arms, second cycle consumes
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            state_q <= flash_status_pkg::SEQ_IDLE;
        else if (wr_idle)
        begin
            unique case (state_q)
                flash_status_pkg::SEQ_IDLE:
                begin
                    if (cmd_lo == flash_status_pkg::CMD_PROGRAM)
                        state_q <= flash_status_pkg::SEQ_PROG_WD;
                    else if (cmd_lo == flash_status_pkg::CMD_BLOCK_ERASE)
                        state_q <= flash_status_pkg::SEQ_ERASE_C;
                end
                default:
                begin
                    state_q <= flash_status_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // Read mode: status after 70 or an operation start, array after FF
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            rd_mode_q <= flash_status_pkg::RD_ARRAY;
        else if (start_prog || start_erase)
            rd_mode_q <= flash_status_pkg::RD_STATUS;
        else if (wr_idle && state_q == flash_status_pkg::SEQ_IDLE
                 && cmd_lo == flash_status_pkg::CMD_READ_STATUS)
            rd_mode_q <= flash_status_pkg::RD_STATUS;
        else if (wr_idle && cmd_lo == flash_status_pkg::CMD_READ_ARRAY
                 && state_q != flash_status_pkg::SEQ_PROG_WD)
            rd_mode_q <= flash_status_pkg::RD_ARRAY;
    end

    // Sequence flag; suspend keeps it busy
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            seq_ready_flag_q <= flash_status_pkg::RST_SEQ_READY;
        else if (start_prog || start_erase)
            seq_ready_flag_q <= 1'b0;
        else if (busy && core_done_in && !erase_suspend_in)
            seq_ready_flag_q <= 1'b1;
    end

    // Which operation the core runs, to classify a failure
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            op_is_erase_q <= 1'b0;
        else if (start_prog || start_erase)
            op_is_erase_q <= start_erase;
    end

    // Erase error flag; a new error wins over a same-cycle clear
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            erase_error_flag_q <= flash_status_pkg::RST_ERR;
        else if (seq_error)
            erase_error_flag_q <= 1'b1;
        else if (op_fail && op_is_erase_q)
            erase_error_flag_q <= 1'b1;
        else if (wr_idle && state_q == flash_status_pkg::SEQ_IDLE
                 && cmd_lo == flash_status_pkg::CMD_CLEAR_STATUS)
            erase_error_flag_q <= 1'b0;
    end

    // Program error flag; same priority scheme
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            program_error_flag_q <= flash_status_pkg::RST_ERR;
        else if (seq_error)
            program_error_flag_q <= 1'b1;
        else if (op_fail && !op_is_erase_q)
            program_error_flag_q <= 1'b1;
        else if (wr_idle && state_q == flash_status_pkg::SEQ_IDLE
                 && cmd_lo == flash_status_pkg::CMD_CLEAR_STATUS)
            program_error_flag_q <= 1'b0;
    end

    // Status byte assembly; reserved positions stay zero
    always_comb
    begin
        status_byte_d = flash_status_pkg::ZERO_BYTE;
        status_byte_d[flash_status_pkg::BIT_SEQ_READY]   = seq_ready_flag_q;
        status_byte_d[flash_status_pkg::BIT_ERASE_ERR]   = erase_error_flag_q;
        status_byte_d[flash_status_pkg::BIT_PROGRAM_ERR] = program_error_flag_q;
    end

    // Registered views of status and control mirror
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            flash_status_byte_out  <= flash_status_pkg::ZERO_BYTE;
            flash_control_reg0_out <= flash_status_pkg::ZERO_BYTE;
        end
        else
        begin
            flash_status_byte_out <= status_byte_d;
            flash_control_reg0_out <= flash_status_pkg::ZERO_BYTE;
            flash_control_reg0_out[flash_status_pkg::CTL_SEQ_READY]   <= seq_ready_flag_q;
            flash_control_reg0_out[flash_status_pkg::CTL_PROGRAM_ERR] <= program_error_flag_q;
            flash_control_reg0_out[flash_status_pkg::CTL_ERASE_ERR]   <= erase_error_flag_q;
        end
    end

    // Read answer one cycle after the strobe; status needs mode zero
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            rd_data_out  <= 16'h0000;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            rd_valid_out <= rom_rd_in;
            if (rom_rd_in && erase_write_mode_zero_in
                && rd_mode_q == flash_status_pkg::RD_STATUS)
                rd_data_out <= {flash_status_pkg::ZERO_BYTE, status_byte_d};
            else if (rom_rd_in)
                rd_data_out <= array_data_in;
        end
    end

    // Launch pulses and captured operands for the core
    always_ff @(posedge clk_sys_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            prog_start_out  <= 1'b0;
            erase_start_out <= 1'b0;
            op_addr_out     <= '0;
            op_data_out     <= 16'h0000;
        end
        else
        begin
            prog_start_out  <= start_prog;
            erase_start_out <= start_erase;
            if (start_prog || start_erase)
            begin
                op_addr_out <= cmd_addr_in;
                op_data_out <= cmd_data_in;
            end
        end
    end

endmodule

`default_nettype wire

/* logic/flash_status_pkg.sv */
package flash_status_pkg;

    // Command codes, low byte of the written word
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM      = 8'h40;
    localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONF   = 8'hD0;

    // Status byte bit positions
    localparam int unsigned BIT_SEQ_READY   = 7;
    localparam int unsigned BIT_ERASE_ERR   = 5;
    localparam int unsigned BIT_PROGRAM_ERR = 4;

    // Control register mirror bit positions
    localparam int unsigned CTL_SEQ_READY   = 0;
    localparam int unsigned CTL_PROGRAM_ERR = 6;
    localparam int unsigned CTL_ERASE_ERR   = 7;

    // Reset values
    localparam logic RST_SEQ_READY = 1'b1;
    localparam logic RST_ERR       = 1'b0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Read mode of the user ROM area
    typedef enum logic [0:0] {
        RD_ARRAY  = 1'b0,
        RD_STATUS = 1'b1
    } read_mode_e;

    // Command sequencer state
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_PROG_WD = 2'b01,
        SEQ_ERASE_C = 2'b10
    } seq_state_e;

endpackage

/* sim/flash_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_core_model (
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    // Launch, fault and pause controls
    input  wire logic       start_in,
    input  wire logic       fail_in,
    input  wire logic       hold_in,
    input  wire logic [7:0] lat_in,
    // Completion towards the tracker
    output logic            core_done_out,
    output logic            core_fail_out
);
    logic [7:0] cnt_q;
    logic       hold_q;

    // Countdown frozen while held; suspend entry reports a done the tracker must ignore
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q         <= 8'h00;
            hold_q        <= 1'b0;
            core_done_out <= 1'b0;
        end
        else
        begin
            hold_q        <= hold_in;
            core_done_out <= (!hold_in && cnt_q == 8'h01)
                             || (hold_in && !hold_q && cnt_q != 8'h00);
            if (start_in)
                cnt_q <= lat_in;
            else if (!hold_in && cnt_q != 8'h00)
                cnt_q <= cnt_q - 8'h01;
        end
    end

    // Fail only means something with done; noise elsewhere
    assign core_fail_out = core_done_out ? fail_in : ~cnt_q[0];
endmodule
`default_nettype wire

/* sim/flash_status_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_status_properties (
    // Clock, reset and CPU side
    input wire logic       clk_sys_in,
    input wire logic       rst_n_in,
    input wire logic       cmd_wr_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic       rom_rd_in,
    // Core side and outputs
    input wire logic       core_done_in,
    input wire logic       erase_suspend_in,
    input wire logic       prog_start_out,
    input wire logic       erase_start_out,
    input wire logic       rd_valid_out,
    input wire logic [7:0] flash_status_byte_out,
    input wire logic [7:0] flash_control_reg0_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // Status reads zero until the synchronised reset lets go
    logic [2:0] live_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
        if (!rst_n_in)
            live_q <= 3'h0;
        else
            live_q <= {live_q[1:0], 1'b1};

    sequence launch_s;
        prog_start_out || erase_start_out;
    endsequence
    sequence busy_done_s;
        core_done_in && !erase_suspend_in && !flash_status_byte_out[7];
    endsequence

    a_busy_on_start: assert property (launch_s |=> !flash_status_byte_out[7])
        else $error("busy not shown after launch");
    a_done_to_ready: assert property (busy_done_s |-> ##2 flash_status_byte_out[7])
        else $error("ready not shown after done");
    a_suspend_holds_busy: assert property (erase_suspend_in ##1
        (live_q[2] && !flash_status_byte_out[7]) |=> !flash_status_byte_out[7])
        else $error("ready shown in suspend");
    a_read_answer: assert property (rom_rd_in ##1 !rom_rd_in |-> rd_valid_out ##1 !rd_valid_out)
        else $error("read answer missing");
    a_start_needs_clean: assert property (launch_s |-> flash_status_byte_out[5:4] == 2'b00)
        else $error("launch with error flag set");
    a_error_sticky: assert property (($fell(flash_status_byte_out[5]) ||
        $fell(flash_status_byte_out[4])) |-> $past(cmd_wr_in, 2) && $past(cmd_data_in[7:0], 2) == 8'h50)
        else $error("error flag cleared without clear command");
    a_mirror_match: assert property (flash_control_reg0_out == {flash_status_byte_out[5],
        flash_status_byte_out[4], 5'h00, flash_status_byte_out[7]})
        else $error("control mirror differs");
    a_reserved_zero: assert property ((flash_status_byte_out & 8'h4F) == 8'h00)
        else $error("reserved status bit set");
endmodule

bind flash_status_tracker flash_status_properties props_chk (
    .clk_sys_in, .rst_n_in, .cmd_wr_in, .cmd_data_in, .rom_rd_in, .core_done_in,
    .erase_suspend_in, .prog_start_out, .erase_start_out, .rd_valid_out,
    .flash_status_byte_out, .flash_control_reg0_out);
`default_nettype wire

/* sim/test_flash_status_tracker.sv */
`timescale 1ns/1ps
`default_nettype none
module test_flash_status_tracker;
    logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, cmd_wr_in = 1'b0, rom_rd_in = 1'b0;
    logic        block_protect_in = 1'b0, erase_suspend_in = 1'b0, fail_req = 1'b0;
    logic        erase_write_mode_zero_in = 1'b1;
    logic        core_done_in, core_fail_in, prog_start_out, erase_start_out, rd_valid_out;
    logic [7:0]  core_lat = 8'h14, flash_status_byte_out, flash_control_reg0_out;
    logic [15:0] cmd_data_in = 16'h0000, op_data_out, rd_data_out;
    logic [19:0] cmd_addr_in = 20'h0ABC4, op_addr_out;
    int          mismatches = 0, samples_checked = 0;
    // 200 MHz clock
    always #2.5 clk_sys_in = ~clk_sys_in;
    flash_status_tracker uut (
        .clk_sys_in, .rst_n_in, .cmd_wr_in, .cmd_addr_in, .cmd_data_in, .rom_rd_in,
        .array_data_in(16'h5A3C), .block_protect_in, .core_done_in, .core_fail_in,
        .erase_suspend_in, .erase_write_mode_zero_in, .prog_start_out,
        .erase_start_out, .op_addr_out, .op_data_out, .rd_data_out, .rd_valid_out,
        .flash_status_byte_out, .flash_control_reg0_out);
    flash_core_model core (.clk_sys_in, .rst_n_in, .start_in(prog_start_out | erase_start_out),
        .fail_in(fail_req), .hold_in(erase_suspend_in), .lat_in(core_lat),
        .core_done_out(core_done_in), .core_fail_out(core_fail_in));
    // Compare and count
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Single write; upper byte is noise the decoder must ignore
    task automatic wr(input logic [7:0] d);
        cmd_wr_in <= 1'b1;
        cmd_data_in <= {8'hC3, d};
        @(posedge clk_sys_in);
        cmd_wr_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // Back-to-back pair, then watch a few cycles for a launch
    task automatic wr2(input logic [15:0] a, input logic [15:0] b, input logic exp);
        logic seen;
        logic ers;
        seen = 1'b0;
        ers = 1'b0;
        cmd_wr_in <= 1'b1;
        cmd_data_in <= a;
        @(posedge clk_sys_in);
        cmd_data_in <= b;
        @(posedge clk_sys_in);
        cmd_wr_in <= 1'b0;
        repeat (6)
        begin
            @(posedge clk_sys_in);
            seen = seen | (prog_start_out === 1'b1) | (erase_start_out === 1'b1);
            ers = ers | (erase_start_out === 1'b1);
        end
        chk("launch", {15'h0000, exp}, {15'h0000, seen});
        chk("launch_erase", {15'h0000, exp && a[7:0] == 8'h20}, {15'h0000, ers});
    endtask
    task automatic rd(input logic [15:0] exp);
        rom_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rom_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        chk("rd_valid", 16'h0001, {15'h0000, rd_valid_out});
        chk("rd_data", exp, rd_data_out);
    endtask
    task automatic st(input logic [7:0] exp);
        wr(8'h70);
        rd({8'h00, exp});
        chk("status_byte", {8'h00, exp}, {8'h00, flash_status_byte_out});
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_ready;
        repeat (400)
            if (flash_status_byte_out[7] !== 1'b1)
                @(posedge clk_sys_in);
        if (flash_status_byte_out[7] !== 1'b1)
        begin
            mismatches++;
            wrap_up();
        end
    endtask
    task automatic t_reset;
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        chk("reset_byte", 16'h0080, {8'h00, flash_status_byte_out});
        chk("reset_ctl", 16'h0001, {8'h00, flash_control_reg0_out});
    endtask
    task automatic t_prog;
        rd(16'h5A3C);
        wr2(16'h0040, 16'hBEEF, 1'b1);
        chk("op_data", 16'hBEEF, op_data_out);
        chk("op_addr", 16'hABC4, op_addr_out[15:0]);
        rd(16'h0000);
        wait_ready();
        st(8'h80);
        fail_req <= 1'b1;
        wr2(16'h0040, 16'h1234, 1'b1);
        wait_ready();
        st(8'h90);
        wr2(16'h0040, 16'h1234, 1'b0);
        wr2(16'h0020, 16'h00D0, 1'b0);
        st(8'h90);
        wr(8'h50);
        st(8'h80);
    endtask
    task automatic t_erase;
        wr2(16'h0020, 16'h00D0, 1'b1);
        chk("op_data_erase", 16'h00D0, op_data_out);
        wait_ready();
        st(8'hA0);
        wr(8'h50);
        fail_req <= 1'b0;
        core_lat <= 8'h28;
        wr2(16'h0020, 16'h00D0, 1'b1);
        erase_suspend_in <= 1'b1;
        repeat (60) @(posedge clk_sys_in);
        chk("suspend_busy", 16'h0000, {15'h0000, flash_status_byte_out[7]});
        erase_suspend_in <= 1'b0;
        wait_ready();
        st(8'h80);
    endtask
    task automatic t_seq;
        logic [32:0] cases [4];
        cases = '{{1'b0, 16'h0020, 16'h0033}, {1'b1, 16'h0040, 16'h0777},
                  {1'b1, 16'h0020, 16'h00D0}, {1'b1, 16'h0020, 16'h00FF}};
        foreach (cases[i])
        begin
            block_protect_in <= cases[i][32];
            wr2(cases[i][31:16], cases[i][15:0], 1'b0);
            st((i == 3) ? 8'h80 : 8'hB0);
            wr(8'h50);
        end
        wr2(16'h0020, 16'h00FF, 1'b0);
        rd(16'h5A3C);
        wr(8'h33);
        st(8'hB0);
    endtask
    // Read-array alone, and status reads only in mode zero
    task automatic t_mode;
        wr(8'h70);
        rd(16'h0080);
        wr(8'hFF);
        rd(16'h5A3C);
        erase_write_mode_zero_in <= 1'b0;
        wr(8'h70);
        rd(16'h5A3C);
        erase_write_mode_zero_in <= 1'b1;
    endtask
    // Main sequence, second reset lands with errors set
    initial
    begin
        t_reset();
        t_prog();
        t_erase();
        t_mode();
        t_seq();
        t_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
